// ---- fifo_flag_pkg.sv ----
// shared constants and types for the fifo status flag block
package fifo_flag_pkg;
  localparam int unsigned DEPTH_DEFAULT = 65536;

  localparam logic [31:0] ADDR_MODE = 32'h0000_0000;
  localparam logic [31:0] ADDR_FULL_OFS = 32'h0000_0004;
  localparam logic [31:0] ADDR_EMPTY_OFS = 32'h0000_0008;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_000C;
  localparam logic [31:0] ADDR_LEVEL = 32'h0000_0010;

  localparam int unsigned MODE_FIRST_WORD_FALLTHROUGH_BIT = 0;
  localparam int unsigned MODE_PFM_BIT = 1;

  localparam int unsigned ST_FULL_BIT = 0;
  localparam int unsigned ST_EMPTY_BIT = 1;
  localparam int unsigned ST_AFULL_BIT = 2;
  localparam int unsigned ST_AEMPTY_BIT = 3;
  localparam int unsigned ST_HALF_BIT = 4;
  localparam int unsigned ST_FIRST_WORD_FALLTHROUGH_BIT = 5;
  localparam int unsigned ST_PFM_BIT = 6;
  localparam int unsigned ST_OUTV_BIT = 7;

  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] FULL_OFS_RESET = 32'h0000_007F;
  localparam logic [31:0] EMPTY_OFS_RESET = 32'h0000_007F;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register stages in front of each pin, the output flop included
  localparam int unsigned FULL_STAGES = 2;
  localparam int unsigned EMPTY_STAGES_STD = 2;
  localparam int unsigned EMPTY_STAGES_FIRST_WORD_FALLTHROUGH = 3;
  localparam int unsigned DELAY_DEPTH = 2;

  typedef struct packed {
    logic full;
    logic empty;
    logic afull;
    logic aempty;
    logic half;
  } flag_set_t;

  // conditions of an empty fifo, active high
  localparam flag_set_t FLAGS_CLEAR = 5'h0A;

  typedef enum logic [2:0] {
    SEL_MODE,
    SEL_FULL_OFS,
    SEL_EMPTY_OFS,
    SEL_STATUS,
    SEL_LEVEL,
    SEL_NONE
  } reg_sel_t;
endpackage

// ---- flag_delay.sv ----
// register chain that delays the flag conditions by whole cycles
`timescale 1ns/1ns
`default_nettype none
module flag_delay
  import fifo_flag_pkg::*;
#(
  parameter int unsigned STAGES = 2
) (
  input wire logic aclk,
  input wire logic clr,
  input wire flag_set_t d,
  output var flag_set_t taps [STAGES]
);
  genvar i;
  generate
    for (i = 0; i < STAGES; i++) begin : g_stage
      always_ff @(posedge aclk) begin
        if (clr) begin
          taps[i] <= FLAGS_CLEAR;
        end else if (i == 0) begin
          taps[i] <= d;
        end else begin
          taps[i] <= taps[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- fifo_status_flags.sv ----
// fifo occupancy tracking, status flag pins and axi4-lite control registers
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - standard mode full pin low while full, high otherwise.
// - standard mode full pin asserts after exactly depth writes.
// - fall-through input-ready low while space exists, high when none.
// - fall-through occupancy counts output register word, depth plus one.
// - full/input-ready passes two register stages on the write clock.
// - standard mode empty pin low while no words, high otherwise.
// - fall-through output-ready goes low when first word reaches outputs.
// - output-ready goes high only on a true read of the last word.
// - empty/output-ready uses two stages standard, three fall-through.
// - standard almost-full asserts after depth minus full offset writes.
// - fall-through almost-full asserts after depth plus one minus offset.
// - almost-full async asserts on write, clears on read; sync registered.
// - standard almost-empty low at empty offset words or fewer.
// - fall-through almost-empty low at empty offset plus one or fewer.
// - almost-empty async asserts on read, clears on write; sync registered.
// - half-full low above half depth, high at half or less.
// - standard half-full low after half depth plus one writes.
// - fall-through half-full low after half depth plus two writes.
// - flag timing select sampled during master reset.
// - write enable ignored while the fifo is full.
module fifo_status_flags
  import fifo_flag_pkg::*;
#(
  parameter int unsigned DEPTH = DEPTH_DEFAULT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic master_reset_n,
  input wire logic partial_reset_n,
  input wire logic wr_en_n,
  input wire logic rd_en_n,
  output logic full_indicator_n,
  output logic empty_indicator_n,
  output logic almost_full_flag_n,
  output logic almost_empty_flag_n,
  output logic half_full_flag_n,
  output logic out_word_valid,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int unsigned CW = $clog2(DEPTH + 2) + 1;
  localparam logic [CW-1:0] DEPTH_W = CW'(DEPTH);
  localparam logic [CW-1:0] HALF_W = CW'(DEPTH / 2);

  function automatic reg_sel_t decode(input logic [31:0] addr);
    if (addr == ADDR_MODE) begin
      return SEL_MODE;
    end else if (addr == ADDR_FULL_OFS) begin
      return SEL_FULL_OFS;
    end else if (addr == ADDR_EMPTY_OFS) begin
      return SEL_EMPTY_OFS;
    end else if (addr == ADDR_STATUS) begin
      return SEL_STATUS;
    end else if (addr == ADDR_LEVEL) begin
      return SEL_LEVEL;
    end else begin
      return SEL_NONE;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                       input logic [31:0] val,
                                       input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // software settings and the copy taken at master reset
  logic [31:0] mode_cfg_ff;
  logic [31:0] full_ofs_ff;
  logic [31:0] empty_ofs_ff;
  logic first_word_fallthrough_ff;
  logic pfm_ff;
  logic [CW-1:0] full_ofs_act_ff;
  logic [CW-1:0] empty_ofs_act_ff;

  // occupancy: memory words plus the fall-through output word
  logic [CW-1:0] occ_ff;
  logic ov_ff;
  logic [CW-1:0] nxt_occ;
  logic nxt_ov;
  logic [CW-1:0] cap;
  logic [CW-1:0] mem_cnt;
  logic wr_ok;
  logic rd_ok;
  logic clr;
  flag_set_t cond;
  flag_set_t taps [DELAY_DEPTH];
  logic afull_sync_ff;
  logic aempty_sync_ff;

  // axi bookkeeping
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic do_write;
  logic nxt_aw_hold;
  logic nxt_w_hold;
  logic nxt_rvalid;
  logic take_ar;
  reg_sel_t wsel;

  assign clr = !aresetn || !master_reset_n || !partial_reset_n;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_word_fallthrough_ff <= 1'b0;
      pfm_ff <= 1'b0;
      full_ofs_act_ff <= '0;
      empty_ofs_act_ff <= '0;
    end else if (!master_reset_n) begin
      // partial reset keeps these, only master reset reloads them
      first_word_fallthrough_ff <= mode_cfg_ff[MODE_FIRST_WORD_FALLTHROUGH_BIT];
      pfm_ff <= mode_cfg_ff[MODE_PFM_BIT];
      full_ofs_act_ff <= full_ofs_ff[CW-1:0];
      empty_ofs_act_ff <= empty_ofs_ff[CW-1:0];
    end
  end

  always_comb begin
    cap = first_word_fallthrough_ff ? DEPTH_W + CW'(1) : DEPTH_W;
    mem_cnt = occ_ff - CW'(ov_ff);
    wr_ok = !wr_en_n && (occ_ff != cap);
    if (first_word_fallthrough_ff) begin
      rd_ok = !rd_en_n && ov_ff;
      if (mem_cnt != '0) begin
        nxt_ov = 1'b1;
      end else if (rd_ok) begin
        nxt_ov = 1'b0;
      end else begin
        nxt_ov = ov_ff;
      end
    end else begin
      rd_ok = !rd_en_n && (occ_ff != '0);
      nxt_ov = 1'b0;
    end
    nxt_occ = occ_ff + CW'(wr_ok) - CW'(rd_ok);
  end

  always_ff @(posedge aclk) begin
    if (clr) begin
      occ_ff <= '0;
      ov_ff <= 1'b0;
    end else begin
      occ_ff <= nxt_occ;
      ov_ff <= nxt_ov;
    end
  end

  // conditions of the state after this edge; wide compares avoid wrap
  always_comb begin
    cond.full = nxt_occ == cap;
    cond.empty = first_word_fallthrough_ff ? !nxt_ov : (nxt_occ == '0);
    cond.afull = {1'b0, nxt_occ} + {1'b0, full_ofs_act_ff}
                 >= {1'b0, cap};
    cond.aempty = {1'b0, nxt_occ} <=
                  {1'b0, empty_ofs_act_ff} + {{CW{1'b0}}, first_word_fallthrough_ff};
    cond.half = nxt_occ > HALF_W + CW'(first_word_fallthrough_ff);
  end

  flag_delay #(
    .STAGES(DELAY_DEPTH)
  ) u_delay (
    .aclk(aclk),
    .clr(clr),
    .d(cond),
    .taps(taps)
  );

  // sync almost flags follow the occupancy a cycle late, never mid-edge
  always_ff @(posedge aclk) begin
    if (clr) begin
      afull_sync_ff <= FLAGS_CLEAR.afull;
      aempty_sync_ff <= FLAGS_CLEAR.aempty;
    end else begin
      afull_sync_ff <= taps[0].afull;
      aempty_sync_ff <= taps[0].aempty;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      full_indicator_n <= 1'b1;
      empty_indicator_n <= 1'b0;
      almost_full_flag_n <= 1'b1;
      almost_empty_flag_n <= 1'b0;
      half_full_flag_n <= 1'b1;
      out_word_valid <= 1'b0;
    end else begin
      // pin polarity flips with the mode
      full_indicator_n <= first_word_fallthrough_ff ? taps[0].full
                                  : !taps[0].full;
      if (first_word_fallthrough_ff) begin
        empty_indicator_n <= taps[1].empty;
      end else begin
        empty_indicator_n <= !taps[0].empty;
      end
      if (pfm_ff) begin
        almost_full_flag_n <= !afull_sync_ff;
        almost_empty_flag_n <= !aempty_sync_ff;
      end else begin
        almost_full_flag_n <= !taps[0].afull;
        almost_empty_flag_n <= !taps[0].aempty;
      end
      half_full_flag_n <= !taps[0].half;
      out_word_valid <= first_word_fallthrough_ff ? taps[1].empty == 1'b0 : 1'b0;
    end
  end

  // write channel: address and data may arrive in either order
  assign wsel = decode(awaddr_ff);
  assign do_write = aw_hold_ff && w_hold_ff && !s_axi_bvalid;

  always_comb begin
    nxt_aw_hold = do_write ? 1'b0 : (aw_hold_ff || (s_axi_awvalid &&
                                     s_axi_awready));
    nxt_w_hold = do_write ? 1'b0 : (w_hold_ff || (s_axi_wvalid &&
                                    s_axi_wready));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      s_axi_awready <= !nxt_aw_hold;
      s_axi_wready <= !nxt_w_hold;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // status and level are read only; writes to them are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_cfg_ff <= MODE_RESET;
      full_ofs_ff <= FULL_OFS_RESET;
      empty_ofs_ff <= EMPTY_OFS_RESET;
    end else if (do_write) begin
      if (wsel == SEL_MODE) begin
        mode_cfg_ff <= merge(mode_cfg_ff, wdata_ff, wstrb_ff);
      end else if (wsel == SEL_FULL_OFS) begin
        full_ofs_ff <= merge(full_ofs_ff, wdata_ff, wstrb_ff);
      end else if (wsel == SEL_EMPTY_OFS) begin
        empty_ofs_ff <= merge(empty_ofs_ff, wdata_ff, wstrb_ff);
      end
    end
  end

  // read channel: one read at a time, answered on the next edge
  assign take_ar = s_axi_arvalid && s_axi_arready;
  assign nxt_rvalid = take_ar || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !nxt_rvalid;
      s_axi_rvalid <= nxt_rvalid;
      if (take_ar) begin
        s_axi_rresp <= RESP_OKAY;
        s_axi_rdata <= '0;
        case (decode(s_axi_araddr))
          SEL_MODE: begin
            s_axi_rdata <= mode_cfg_ff;
          end
          SEL_FULL_OFS: begin
            s_axi_rdata <= full_ofs_ff;
          end
          SEL_EMPTY_OFS: begin
            s_axi_rdata <= empty_ofs_ff;
          end
          SEL_STATUS: begin
            s_axi_rdata[ST_FULL_BIT] <= full_indicator_n;
            s_axi_rdata[ST_EMPTY_BIT] <= empty_indicator_n;
            s_axi_rdata[ST_AFULL_BIT] <= almost_full_flag_n;
            s_axi_rdata[ST_AEMPTY_BIT] <= almost_empty_flag_n;
            s_axi_rdata[ST_HALF_BIT] <= half_full_flag_n;
            s_axi_rdata[ST_FIRST_WORD_FALLTHROUGH_BIT] <= first_word_fallthrough_ff;
            s_axi_rdata[ST_PFM_BIT] <= pfm_ff;
            s_axi_rdata[ST_OUTV_BIT] <= ov_ff;
          end
          SEL_LEVEL: begin
            s_axi_rdata <= 32'(occ_ff);
          end
          default: begin
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- fifo_status_flags_checker.sv ----
// assertions on the flag pins and the register bus
`timescale 1ns/1ns
`default_nettype none
module fifo_status_flags_checker
  import fifo_flag_pkg::*;
#(
  parameter int unsigned DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic master_reset_n,
  input wire logic partial_reset_n,
  input wire logic wr_en_n,
  input wire logic rd_en_n,
  input wire logic full_indicator_n,
  input wire logic empty_indicator_n,
  input wire logic almost_full_flag_n,
  input wire logic almost_empty_flag_n,
  input wire logic half_full_flag_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  logic shd_ff;
  logic first_word_fallthrough_ff;
  logic [2:0] quiet_ff;
  int unsigned occ_ff;
  wire quiet = &quiet_ff;
  wire wtake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  // pin meaning only flips at a master reset, so shadow the mode bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shd_ff <= 1'h0;
      first_word_fallthrough_ff <= 1'h0;
    end else begin
      if (wtake && s_axi_awaddr == ADDR_MODE) shd_ff <= s_axi_wdata[0];
      if (!master_reset_n) first_word_fallthrough_ff <= shd_ff;
    end
  end

  // standard mode occupancy only; pins settle three edges after any reset
  always_ff @(posedge aclk) begin
    if (!aresetn || !master_reset_n || !partial_reset_n) begin
      occ_ff <= 0;
      quiet_ff <= 3'h0;
    end else begin
      occ_ff <= occ_ff + (!wr_en_n && occ_ff < DEPTH) - (!rd_en_n && occ_ff > 0);
      quiet_ff <= {quiet_ff[1:0], 1'h1};
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reset_flags: assert property ($rose(aresetn) |->
    full_indicator_n && !empty_indicator_n && almost_full_flag_n
    && !almost_empty_flag_n && half_full_flag_n)
    else $error("flags not empty after reset");
  a_full_std: assert property (
    !first_word_fallthrough_ff && quiet |-> full_indicator_n == ($past(occ_ff) != DEPTH))
    else $error("full pin wrong");
  a_empty_std: assert property (
    !first_word_fallthrough_ff && quiet |-> empty_indicator_n == ($past(occ_ff) != 0))
    else $error("empty pin wrong");
  a_half_std: assert property (
    !first_word_fallthrough_ff && quiet |-> half_full_flag_n == ($past(occ_ff) <= DEPTH / 2))
    else $error("half pin wrong");
  a_full_holds: assert property (
    !first_word_fallthrough_ff && quiet && !full_indicator_n && $past(rd_en_n)
    |=> !full_indicator_n)
    else $error("write taken while full");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (wtake |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while read pending");
endmodule
bind fifo_status_flags fifo_status_flags_checker #(.DEPTH(DEPTH))
  u_fifo_status_flags_checker (.*);
`default_nettype wire

// ---- fifo_agents.sv ----
// write and read agents on the far side of the flag pins
`timescale 1ns/1ns
`default_nettype none
module fifo_agents (
  input wire logic aclk,
  input wire logic first_word_fallthrough,
  input wire logic rude,
  input wire logic wr_want,
  input wire logic rd_want,
  input wire logic full_indicator_n,
  input wire logic empty_indicator_n,
  output var logic wr_en_n = 1'h1,
  output var logic rd_en_n = 1'h1
);
  // rude ignores the flags, only to probe refusal inside the block
  always @(posedge aclk) begin
    wr_en_n <= !(wr_want && (rude || full_indicator_n != first_word_fallthrough));
    rd_en_n <= !(rd_want && (rude || empty_indicator_n != first_word_fallthrough));
  end
endmodule
`default_nettype wire

// ---- test_fifo_status_flag_logic.sv ----
// self-checking bench for the fifo status flag block
`timescale 1ns/1ns
`default_nettype none
module test_fifo_status_flag_logic;
  import fifo_flag_pkg::*;
  localparam int D = 16;
  logic aclk = 1'h0, aresetn = 1'h0, master_reset_n = 1'h1;
  logic partial_reset_n = 1'h1, first_word_fallthrough = 1'h0, flag_timing_select = 1'h0, rude = 1'h1;
  logic wr_want = 1'h0, rd_want = 1'h0, rnd = 1'h0;
  logic wr_en_n, rd_en_n, full_indicator_n, empty_indicator_n;
  logic almost_full_flag_n, almost_empty_flag_n, half_full_flag_n;
  logic out_word_valid, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [33:0] exp_q [$];
  int error_cnt = 0, n_checks = 0, occ = 0, m = 0, n = 0;

  fifo_status_flags #(.DEPTH(D)) u_fifo_status_flags (.*);
  fifo_agents u_fifo_agents (.*);

  always #5 aclk = ~aclk;

  task chk(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (rnd) occ <= occ + (!wr_en_n && occ < D) - (!rd_en_n && occ > 0);
  end

  task bus(input logic w, input logic [31:0] a, input logic [31:0] d,
           input logic [33:0] e);
    int i;
    exp_q.push_back(e);
    @(posedge aclk);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
    end
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    if (i == 40) begin
      error_cnt++;
      results();
    end
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'h1, a, d, {RESP_OKAY, 32'h0});
  endtask

  task rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0, {RESP_OKAY, e});
  endtask

  // status word as the pins should settle for k words held
  function automatic logic [31:0] st(input int k, input logic f, input logic p);
    return {24'h0, f && k > 0, p, f, !(k > D / 2 + f), !(k <= n + f),
      !(k >= D + f - m), f ? k == 0 : k != 0, f ? k == D + 1 : k != D};
  endfunction

  task step(input logic w, input int k);
    if (w) wr_want <= 1'h1;
    else rd_want <= 1'h1;
    @(posedge aclk);
    wr_want <= 1'h0;
    rd_want <= 1'h0;
    repeat (6) @(posedge aclk);
    chk(34'(out_word_valid), 34'(first_word_fallthrough && k > 0));
    rd(ADDR_STATUS, st(k, first_word_fallthrough, flag_timing_select));
    rd(ADDR_LEVEL, 32'(k));
  endtask

  task mreset;
    master_reset_n <= 1'h0;
    repeat (2) @(posedge aclk);
    master_reset_n <= 1'h1;
    repeat (3) @(posedge aclk);
  endtask

  initial begin
    void'($urandom(32981));
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    rd(ADDR_STATUS, st(0, 1'h0, 1'h0));
    rd(ADDR_MODE, MODE_RESET);
    rd(ADDR_FULL_OFS, FULL_OFS_RESET);
    rd(ADDR_EMPTY_OFS, EMPTY_OFS_RESET);
    wr(ADDR_LEVEL, 32'hF);
    rd(ADDR_LEVEL, 32'h0);
    bus(1'h0, 32'h40, 32'h0, {RESP_SLVERR, 32'h0});
    for (int md = 0; md < 4; md++) begin
      m = $urandom_range(5, 1);
      n = $urandom_range(5, 1);
      wr(ADDR_MODE, 32'(md));
      wr(ADDR_FULL_OFS, 32'(m));
      wr(ADDR_EMPTY_OFS, 32'(n));
      rd(ADDR_FULL_OFS, 32'(m));
      {flag_timing_select, first_word_fallthrough} <= 2'(md);
      mreset();
      // past capacity on purpose: the surplus strobes must be ignored
      for (int i = 1; i <= D + 2; i++) begin
        step(1'h1, i > D + first_word_fallthrough ? D + first_word_fallthrough : i);
      end
      for (int i = D + first_word_fallthrough - 1; i >= -1; i--) begin
        step(1'h0, i < 0 ? 0 : i);
      end
    end
    step(1'h1, 1);
    step(1'h1, 2);
    wr(ADDR_MODE, 32'h0);
    partial_reset_n <= 1'h0;
    repeat (2) @(posedge aclk);
    partial_reset_n <= 1'h1;
    rd(ADDR_STATUS, st(0, 1'h1, 1'h1));
    rd(ADDR_LEVEL, 32'h0);
    {flag_timing_select, first_word_fallthrough} <= 2'h0;
    mreset();
    rude <= 1'h0;
    rnd <= 1'h1;
    // writes outweigh reads so the full pin is reached and honoured
    repeat (400) begin
      @(posedge aclk);
      wr_want <= ($urandom % 4) != 0;
      rd_want <= 1'($urandom);
    end
    @(posedge aclk);
    wr_want <= 1'h0;
    rd_want <= 1'h0;
    repeat (4) @(posedge aclk);
    rd(ADDR_LEVEL, 32'(occ));
    rd(ADDR_STATUS, st(occ, 1'h0, 1'h0));
    results();
  end
endmodule
`default_nettype wire
